// ---- hw/psbp_ctl.sv ----
// module: controller end, issues single or four-word burst accesses
`timescale 1ns/1ps
module psbp_ctl
  import psbp_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // user request
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic              req_burst,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [BYTES-1:0]  req_be_n,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              req_linear,
  input  wire logic              hold,
  output logic                   req_ready,
  // read return
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  // pins
  psbp_if.ctl                    bus
);

  // ****************************************
  // issue stage
  // ****************************************
  logic [1:0] beats_reg;
  logic       bursting_reg;
  logic       bwrite_reg;
  logic       issue;
  // the request is taken only on an edge that the memory end also sees
  assign issue = req_valid && req_ready;

  logic [ADDR_W-1:0] addr_reg;
  logic              rw_reg, adv_reg, cs_n_reg, hold_n_reg, lbo_n_reg, rdy_reg;
  logic [BYTES-1:0]  be_reg;
  logic [DATA_W-1:0] wdata_issue;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg     <= '0;
      rw_reg       <= 1'b1;
      adv_reg      <= 1'b0;
      cs_n_reg     <= 1'b1;
      hold_n_reg   <= 1'b0;
      lbo_n_reg    <= 1'b1;
      be_reg       <= '1;
      beats_reg    <= 2'h0;
      bursting_reg <= 1'b0;
      bwrite_reg   <= 1'b0;
      rdy_reg      <= 1'b0;
    end else begin
      hold_n_reg <= hold;
      // follow the registered enable pin so both ends skip the same edges
      if (!hold_n_reg) begin
        rdy_reg <= 1'b1;
        if (bursting_reg) begin
          adv_reg   <= 1'b1;
          be_reg    <= req_be_n;
          beats_reg <= beats_reg + BURST_STEP;
          if (beats_reg == BURST_LAST - BURST_STEP) begin
            bursting_reg <= 1'b0;
            rdy_reg      <= 1'b1;
          end else begin
            rdy_reg      <= 1'b0;
          end
        end else if (issue) begin
          adv_reg      <= 1'b0;
          addr_reg     <= req_addr;
          rw_reg       <= !req_write;
          cs_n_reg     <= 1'b0;
          lbo_n_reg    <= !req_linear;
          be_reg       <= req_be_n;
          bwrite_reg   <= req_write;
          bursting_reg <= req_burst;
          beats_reg    <= 2'h0;
          rdy_reg      <= !req_burst;
        end else begin
          adv_reg  <= 1'b0;
          cs_n_reg <= 1'b1; // deselect cycle
        end
      end
    end
  end
  assign req_ready = rdy_reg && !bursting_reg && !hold_n_reg;

  // ****************************************
  // write data and read capture pipeline
  // ****************************************
  // data lags pins by two enabled edges; one stage registers the pins
  logic [DATA_W-1:0] wd_reg [PIPE_DEPTH+1];
  logic              wv_reg [PIPE_DEPTH+1];
  logic              rv_reg [PIPE_DEPTH+1];
  logic              step;
  assign step = !hold_n_reg;
  logic cyc_write, cyc_read;
  assign cyc_write = (issue && req_write) || (bursting_reg && bwrite_reg);
  assign cyc_read  = (issue && !req_write) || (bursting_reg && !bwrite_reg);
  assign wdata_issue = req_wdata;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i <= PIPE_DEPTH; i++) begin
        wd_reg[i] <= '0;
        wv_reg[i] <= 1'b0;
        rv_reg[i] <= 1'b0;
      end
    end else if (step) begin
      wd_reg[0] <= wdata_issue;
      wv_reg[0] <= cyc_write;
      rv_reg[0] <= cyc_read;
      for (int i = 1; i <= PIPE_DEPTH; i++) begin
        wd_reg[i] <= wd_reg[i-1];
        wv_reg[i] <= wv_reg[i-1];
        rv_reg[i] <= rv_reg[i-1];
      end
    end
  end

  logic              rd_valid_reg;
  logic [DATA_W-1:0] rd_data_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
    end else begin
      rd_valid_reg <= step && rv_reg[PIPE_DEPTH];
      if (step && rv_reg[PIPE_DEPTH]) begin
        rd_data_reg <= bus.dq_in;
      end
    end
  end

  assign rd_valid = rd_valid_reg;
  assign rd_data  = rd_data_reg;

  assign bus.addr                 = addr_reg;
  assign bus.rw_sel               = rw_reg;
  assign bus.advance_load_n       = adv_reg;
  assign bus.clock_hold_n         = hold_n_reg;
  assign bus.byte_write_strobes_n = be_reg;
  assign bus.burst_order_select_n = lbo_n_reg;
  assign bus.chip_select_a_n      = cs_n_reg;
  assign bus.chip_select_b_n      = cs_n_reg;
  assign bus.chip_select_high     = !cs_n_reg;
  // the last stage stands in the cycle whose closing edge the memory writes on
  assign bus.dq_ctl_out           = wd_reg[PIPE_DEPTH];
  assign bus.dq_ctl_oe_n          = !wv_reg[PIPE_DEPTH];

endmodule // psbp_ctl

// ---- hw/psbp_pkg.sv ----
// package: shared constants and types for the pipelined burst sram port
package psbp_pkg;
  localparam int ADDR_W      = 18;
  localparam int DATA_W      = 18;
  localparam int BYTES       = 2;
  localparam int PIPE_DEPTH  = 2;
  localparam int MEM_WORDS   = 1024;
  localparam int MEM_AW      = 10;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] BURST_LAST = 2'h3;

  typedef enum logic [1:0] {
    PSBP_IDLE  = 2'b00,
    PSBP_READ  = 2'b01,
    PSBP_WRITE = 2'b10
  } psbp_op_t;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [ADDR_W-1:0]     addr;
    logic [BYTES-1:0]      be_n;
  } psbp_slot_t;

  // word address within a burst: linear adds, interleaved xors
  function automatic logic [1:0] psbp_burst_lsb(input logic [1:0] base,
                                               input logic [1:0] cnt,
                                               input logic       linear);
    psbp_burst_lsb = linear ? 2'(base + cnt) : (base ^ cnt);
  endfunction
endpackage

// ---- hw/psbp_if.sv ----
// interface: pins between the memory controller and the sram port
`timescale 1ns/1ps
interface psbp_if;
  import psbp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              rw_sel;
  logic              advance_load_n;
  logic              clock_hold_n;
  logic [BYTES-1:0]  byte_write_strobes_n;
  logic              burst_order_select_n;
  logic              chip_select_a_n;
  logic              chip_select_b_n;
  logic              chip_select_high;
  logic [DATA_W-1:0] dq_ctl_out;
  logic              dq_ctl_oe_n;
  logic [DATA_W-1:0] dq_mem_out;
  logic              dq_mem_oe_n;
  logic [DATA_W-1:0] dq_in;
  always_comb begin
    if (!dq_mem_oe_n)
      dq_in = dq_mem_out;
    else if (!dq_ctl_oe_n)
      dq_in = dq_ctl_out;
    else
      dq_in = '0;
  end
  modport mem (
    input  addr, rw_sel, advance_load_n, clock_hold_n, byte_write_strobes_n,
    input  burst_order_select_n, chip_select_a_n, chip_select_b_n, chip_select_high,
    input  dq_in,
    output dq_mem_out, dq_mem_oe_n
  );
  modport ctl (
    output addr, rw_sel, advance_load_n, clock_hold_n, byte_write_strobes_n,
    output burst_order_select_n, chip_select_a_n, chip_select_b_n, chip_select_high,
    output dq_ctl_out, dq_ctl_oe_n,
    input  dq_in
  );
endinterface

// ---- hw/psbp_mem.sv ----
// module: device end, pipelined synchronous burst sram with four-word burst
`timescale 1ns/1ps
module psbp_mem
  import psbp_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // pins
  psbp_if.mem       bus
);

  // ****************************************
  // input sampling and edge gating
  // ****************************************
  // pins come from logic on the same clock, so no synchroniser is needed
  logic edge_en;
  assign edge_en = !bus.clock_hold_n;

  logic selected;
  assign selected = !bus.chip_select_a_n && !bus.chip_select_b_n && bus.chip_select_high;

  // ****************************************
  // burst state
  // ****************************************
  logic [ADDR_W-1:0] base_reg;
  logic [1:0]        cnt_reg;
  logic              write_reg;
  logic              active_reg;
  logic              linear_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_reg   <= '0;
      cnt_reg    <= 2'h0;
      write_reg  <= 1'b0;
      active_reg <= 1'b0;
      linear_reg <= 1'b0;
    end else if (edge_en) begin
      if (!bus.advance_load_n) begin
        base_reg   <= bus.addr;
        cnt_reg    <= 2'h0;
        write_reg  <= !bus.rw_sel;
        active_reg <= selected;
        linear_reg <= !bus.burst_order_select_n;
      end else if (active_reg && cnt_reg != BURST_LAST) begin
        cnt_reg    <= cnt_reg + BURST_STEP;
      end else begin
        active_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // address/control slot for this edge
  // ****************************************
  psbp_slot_t slot_now;
  logic [1:0] next_cnt;
  always_comb begin
    next_cnt = cnt_reg + BURST_STEP;
    slot_now = '0;
    if (!bus.advance_load_n) begin
      slot_now.valid = selected;
      slot_now.write = !bus.rw_sel;
      slot_now.addr  = bus.addr;
    end else if (active_reg && cnt_reg != BURST_LAST) begin
      slot_now.valid = 1'b1;
      slot_now.write = write_reg;
      // only the two low bits step, upper bits stay at the loaded value
      slot_now.addr  = {base_reg[ADDR_W-1:2],
                        psbp_burst_lsb(base_reg[1:0], next_cnt, linear_reg)};
    end
    slot_now.be_n = bus.byte_write_strobes_n;
  end

  // ****************************************
  // two-stage pipeline to the data phase
  // ****************************************
  psbp_slot_t pipe_reg [PIPE_DEPTH];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_reg[i] <= '0;
      end
    end else if (edge_en) begin
      pipe_reg[0] <= slot_now;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  psbp_slot_t data_slot;
  assign data_slot = pipe_reg[PIPE_DEPTH-1];

  // ****************************************
  // storage and data bus
  // ****************************************
  // array is smaller than the address space; upper bits alias
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [MEM_AW-1:0] data_idx;
  assign data_idx = data_slot.addr[MEM_AW-1:0];
  localparam int LANE_W = DATA_W / BYTES;

  always_ff @(posedge clk) begin
    if (edge_en && data_slot.valid && data_slot.write) begin
      for (int b = 0; b < BYTES; b++) begin
        if (!data_slot.be_n[b]) begin
          mem[data_idx][b*LANE_W +: LANE_W] <= bus.dq_in[b*LANE_W +: LANE_W];
        end
      end
    end
  end

  logic [DATA_W-1:0] dq_out_reg;
  logic              dq_oe_n_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_out_reg  <= '0;
      dq_oe_n_reg <= 1'b1;
    end else if (edge_en) begin
      // drive is timed to the data phase of the access one stage earlier
      if (pipe_reg[0].valid && !pipe_reg[0].write) begin
        dq_out_reg  <= mem[pipe_reg[0].addr[MEM_AW-1:0]];
        dq_oe_n_reg <= 1'b0;
      end else begin
        dq_oe_n_reg <= 1'b1;
      end
    end
  end

  assign bus.dq_mem_out  = dq_out_reg;
  assign bus.dq_mem_oe_n = dq_oe_n_reg;

endmodule // psbp_mem

// ---- verification/psbp_props.sv ----
// checker: timing properties on the pins between the two port ends
`timescale 1ns/1ps
module psbp_props
  import psbp_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // pins
  input wire logic              clock_hold_n,
  input wire logic              advance_load_n,
  input wire logic              rw_sel,
  input wire logic              chip_select_a_n,
  input wire logic              chip_select_b_n,
  input wire logic              chip_select_high,
  input wire logic [DATA_W-1:0] dq_mem_out,
  input wire logic              dq_mem_oe_n,
  input wire logic              dq_ctl_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ********
  // burst mirror
  // ********
  logic       rd_reg;
  logic [1:0] left_reg;
  wire        en  = !clock_hold_n;
  wire        sel = !chip_select_a_n && !chip_select_b_n && chip_select_high;
  wire        ld  = en && !advance_load_n && sel;
  wire        bt  = ld || (en && advance_load_n && left_reg != 2'h0);
  wire        rd  = ld ? rw_sel : rd_reg;
  // direction is latched at the load edge only, so rw_sel is not looked at mid-burst
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_reg   <= 1'b0;
      left_reg <= 2'h0;
    end else if (en && !advance_load_n) begin
      rd_reg   <= rw_sel;
      left_reg <= sel ? 2'h3 : 2'h0;
    end else if (en && left_reg != 2'h0) begin
      left_reg <= left_reg - 2'h1;
    end
  end
  sequence s_rd;
    bt && rd ##1 en;
  endsequence
  sequence s_wr;
    bt && !rd ##1 en;
  endsequence
  a_read_phase: assert property (s_rd |=> !dq_mem_oe_n)
    else $error("read data not driven in its data phase");
  a_write_mem_quiet: assert property (s_wr |=> dq_mem_oe_n)
    else $error("memory drives during a write data phase");
  a_write_ctl_drive: assert property (s_wr |=> !dq_ctl_oe_n)
    else $error("write data not driven two cycles after strobes");
  a_deselect_quiet: assert property (en && !advance_load_n && !sel ##1 en |=> dq_mem_oe_n)
    else $error("deselected load still drives data");
  a_hold_keeps_oe: assert property (!en |=> $stable(dq_mem_oe_n))
    else $error("output enable moved on a held edge");
  a_hold_keeps_data: assert property (!en && !dq_mem_oe_n |=> $stable(dq_mem_out))
    else $error("read data moved on a held edge");
  a_select_polarity: assert property (en && !advance_load_n && !chip_select_a_n
                                      |-> chip_select_high && !chip_select_b_n)
    else $error("chip selects disagree");
  a_reset_hiz: assert property ($fell(sys_rst) |-> dq_mem_oe_n [*3])
    else $error("data driven right after reset");
endmodule // psbp_props

// ---- verification/testbench.sv ----
// testbench: controller and memory ends joined, user side driven and checked
`timescale 1ns/1ps
module testbench;
  import psbp_pkg::*;
  // ********
  // user side and instances
  // ********
  logic              clk, sys_rst, req_valid, req_write, req_burst, req_linear, hold;
  logic              req_ready, rd_valid;
  logic [ADDR_W-1:0] req_addr;
  logic [BYTES-1:0]  req_be_n;
  logic [DATA_W-1:0] req_wdata, rd_data;
  logic [DATA_W-1:0] rdq[$];
  int                err_total = 0;
  int                cmp_count = 0;
  psbp_if bus ();
  psbp_mem i_psbp_mem (.clk(clk), .sys_rst(sys_rst), .bus(bus.mem));
  psbp_ctl i_psbp_ctl (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_write(req_write), .req_burst(req_burst), .req_addr(req_addr), .req_be_n(req_be_n),
    .req_wdata(req_wdata), .req_linear(req_linear), .hold(hold), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .bus(bus.ctl));
  psbp_props i_psbp_props (.clk(clk), .sys_rst(sys_rst), .clock_hold_n(bus.clock_hold_n),
    .advance_load_n(bus.advance_load_n), .rw_sel(bus.rw_sel),
    .chip_select_a_n(bus.chip_select_a_n), .chip_select_b_n(bus.chip_select_b_n),
    .chip_select_high(bus.chip_select_high), .dq_mem_out(bus.dq_mem_out),
    .dq_mem_oe_n(bus.dq_mem_oe_n), .dq_ctl_oe_n(bus.dq_ctl_oe_n));
  always @(posedge clk) if (rd_valid === 1'b1) rdq.push_back(rd_data);
  // ********
  // tasks
  // ********
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // a burst write steps its data by one each beat; valid stays up after a single
  task automatic issue(input logic w, b, lin, input logic [ADDR_W-1:0] a,
                       input logic [BYTES-1:0] be, input logic [DATA_W-1:0] d);
    for (int n = 0; req_ready !== 1'b1; n++) begin
      if (n > 40) begin
        err_total++;
        print_verdict();
      end
      tick(1);
    end
    {req_valid, req_write, req_burst, req_linear} = {1'b1, w, b, lin};
    req_addr  = a;
    req_be_n  = be;
    req_wdata = d;
    tick(1);
    if (b)
      req_valid = 1'b0;
    for (int k = 1; k < 4 && b; k++) begin
      req_wdata = d + 18'(k);
      tick(1);
    end
  endtask
  task automatic wait_rd(input int n);
    for (int i = 0; i < 60 && rdq.size() < n; i++) tick(1);
    if (rdq.size() < n) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic t_single();
    for (int i = 0; i < 4; i++) issue(1'b1, 1'b0, 1'b0, 18'h100 + 18'(i), 2'h0, 18'h12300 + 18'(i));
    issue(1'b1, 1'b0, 1'b0, 18'h104, 2'h0, 18'h3ffff);
    issue(1'b1, 1'b0, 1'b0, 18'h104, 2'h1, 18'h00000);
    for (int i = 0; i < 5; i++) issue(1'b0, 1'b0, 1'b0, 18'h100 + 18'(i), 2'h0, '0);
    req_valid = 1'b0;
    wait_rd(5);
    for (int i = 0; i < 5; i++) chk(rdq.pop_front(), i < 4 ? 18'h12300 + 18'(i) : 18'h001ff);
  endtask
  // base offset 1 tells linear (1,2,3,0) from interleaved (1,0,3,2)
  task automatic t_burst(input logic lin);
    logic [ADDR_W-1:0] b;
    b = lin ? 18'h10d : 18'h111;
    issue(1'b1, 1'b1, lin, b, 2'h0, 18'h00200);
    for (int k = 0; k < 4; k++)
      issue(1'b0, 1'b0, 1'b0, {b[17:2], lin ? 2'(b[1:0] + k) : b[1:0] ^ 2'(k)}, 2'h0, '0);
    issue(1'b0, 1'b1, lin, b, 2'h0, '0);
    wait_rd(8);
    for (int k = 0; k < 8; k++) chk(rdq.pop_front(), 18'h00200 + 18'(k % 4));
  endtask
  task automatic t_hold();
    fork
      issue(1'b0, 1'b1, 1'b1, 18'h10d, 2'h0, '0);
      begin
        tick(1);
        hold = 1'b1;
        tick(3);
        hold = 1'b0;
      end
    join
    wait_rd(4);
    for (int k = 0; k < 4; k++) chk(rdq.pop_front(), 18'h00200 + 18'(k));
  endtask
  // ********
  // run
  // ********
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {sys_rst, req_valid, req_write, req_burst, req_linear, hold} = 6'h20;
    req_addr  = '0;
    req_be_n  = '0;
    req_wdata = '0;
    tick(16);
    sys_rst = 1'b0;
    tick(2);
    chk({17'h0, bus.dq_mem_oe_n}, 18'h1);
    t_single();
    t_burst(1'b1);
    t_burst(1'b0);
    t_hold();
    print_verdict();
  end
endmodule // testbench
